// >>> design/lae_top.sv
// Local design decisions: the address map and the AHB-Lite interface to the registers.
module lae_top #(
  parameter int CNT_W = 16  // Width of the frame counters
) (
  input  wire logic        hclk,                     // Clock
  input  wire logic        hresetn,                  // Async reset, active low
  input  wire logic        hsel,                     // AHB slave select
  input  wire logic [31:0] haddr,                    // AHB address
  input  wire logic [1:0]  htrans,                   // AHB transfer type
  input  wire logic        hwrite,                   // AHB write
  input  wire logic [2:0]  hsize,                    // AHB size, word only
  input  wire logic [31:0] hwdata,                   // AHB write data
  input  wire logic        hready,                   // AHB bus ready
  output logic             hreadyout,                // Always ready
  output logic             hresp,                    // Always OKAY
  output logic      [31:0] hrdata,                   // AHB read data
  input  wire logic        tx_line_tick,             // Line wants an octet
  output logic      [7:0]  tx_line_data,             // Octet to the line
  output logic             tx_byte_boundary_strobe,  // Octet boundary
  input  wire logic        tx_in_valid,              // MAC octet valid
  input  wire logic [7:0]  tx_in_data,               // MAC octet
  input  wire logic        tx_in_last,               // Last octet of frame
  output logic             tx_in_ready,              // MAC octet taken
  input  wire logic [7:0]  rx_line_data,             // Octet from the line
  input  wire logic        rx_byte_boundary_strobe,  // Octet boundary
  output logic             rx_out_valid,             // FIFO octet valid
  output logic      [7:0]  rx_out_data,              // FIFO octet
  output logic             rx_out_start,             // First payload octet
  output logic             rx_out_end,               // Last octet of frame
  output logic             rx_out_abort              // Frame must be dropped
);
  import lae_pkg::*;

  typedef struct packed {
    lae_tx_state_t    tx_state;
    logic [1:0]       tx_idx;
    logic             tx_esc_pend;
    logic [7:0]       tx_esc_oct;
    logic [31:0]      tx_crc;
    logic [7:0]       tx_data;
    logic             tx_strobe;
    lae_rx_state_t    rx_state;
    logic             rx_esc;
    logic [3:0]       rx_cnt;
    logic             rx_hdr_bad;
    logic [31:0]      rx_crc;
    logic             hold_valid;
    logic [7:0]       hold_data;
    logic             hold_start;
    logic             out_valid;
    logic [7:0]       out_data;
    logic             out_start;
    logic             out_end;
    logic             out_abort;
    logic [2:0]       ctrl;
    logic [31:0]      hdr;
    logic [CNT_W-1:0] ok_cnt;
    logic [CNT_W-1:0] abt_cnt;
    logic             ph_wr;
    logic [7:0]       ph_addr;
    logic [31:0]      hrdata;
  } lae_top_st_t;

  localparam lae_top_st_t      ST_RST  = '{tx_state: LAE_TX_IDLE, rx_state: LAE_RX_HUNT, ctrl: LAE_CTRL_RST,
                                           hdr: LAE_HDR_RST, tx_crc: LAE_CRC_INIT, rx_crc: LAE_CRC_INIT,
                                           default: '0};
  localparam logic [CNT_W-1:0] CNT_ONE = 1;

  lae_top_st_t st_reg;
  lae_top_st_t st_next;
  logic        mode;
  logic [7:0]  tx_octet;
  logic [7:0]  tx_raw;
  logic        tx_use_raw;
  logic [7:0]  tx_scr_out;
  logic [7:0]  rx_d;
  logic        rx_accept;
  logic [7:0]  rx_acc;
  logic        rx_fin;
  logic        rx_force;
  logic        rx_bad;
  logic        rx_restart;
  logic        rx_hunt;

  assign mode = st_reg.ctrl[LAE_CTRL_MODE];

  // Transmit scrambler sits after the closing flag is chosen
  lae_scrambler #(
    .DESCRAMBLE (1'b0)
  ) u_tx_scr (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .advance   (tx_line_tick),
    .bypass    (!st_reg.ctrl[LAE_CTRL_SCR]),
    .in_octet  (tx_octet),
    .out_octet (tx_scr_out)
  );

  // Receive descrambler is first in line, ahead of the flag search
  lae_scrambler #(
    .DESCRAMBLE (1'b1)
  ) u_rx_dsc (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .advance   (rx_byte_boundary_strobe),
    .bypass    (!st_reg.ctrl[LAE_CTRL_DSC]),
    .in_octet  (rx_line_data),
    .out_octet (rx_d)
  );  // see R8

  // Handshakes and bus answers; data outputs are straight from flip-flops
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign hrdata                  = st_reg.hrdata;
  assign tx_line_data            = st_reg.tx_data;
  assign tx_byte_boundary_strobe = st_reg.tx_strobe;
  assign tx_in_ready             = tx_line_tick && (!mode || (st_reg.tx_state == LAE_TX_DATA && !st_reg.tx_esc_pend));
  assign rx_out_valid            = st_reg.out_valid;
  assign rx_out_data             = st_reg.out_data;
  assign rx_out_start            = st_reg.out_start;
  assign rx_out_end              = st_reg.out_end;
  assign rx_out_abort            = st_reg.out_abort;

  // Next state of bus slave, transmit framer and receive deframer
  always_comb begin
    st_next    = st_reg;
    tx_octet   = LAE_FLAG;
    tx_raw     = 8'h00;
    tx_use_raw = 1'b0;
    rx_accept  = 1'b0;
    rx_acc     = 8'h00;
    rx_fin     = 1'b0;
    rx_force   = 1'b0;
    rx_bad     = 1'b0;
    rx_restart = 1'b0;
    rx_hunt    = 1'b0;

    // Data phase write lands before the read mux, so a read right after
    // a write to the same register already sees the new value
    if (st_reg.ph_wr) begin
      case (st_reg.ph_addr)
        LAE_OFF_CTRL: st_next.ctrl = hwdata[2:0];  // see R3
        LAE_OFF_HDR:  st_next.hdr  = hwdata;        // see R4
        default:      ;
      endcase
    end
    st_next.ph_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      st_next.ph_wr   = hwrite;
      st_next.ph_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          LAE_OFF_CTRL:   st_next.hrdata = {29'h00000000, st_next.ctrl};
          LAE_OFF_HDR:    st_next.hrdata = st_next.hdr;
          LAE_OFF_RX_OK:  st_next.hrdata = {{(32-CNT_W){1'b0}}, st_reg.ok_cnt};
          LAE_OFF_RX_ABT: st_next.hrdata = {{(32-CNT_W){1'b0}}, st_reg.abt_cnt};
          default:        st_next.hrdata = 32'h00000000;
        endcase
      end
    end

    // Transmit octet per line tick; an underrun cannot stall a TDM line,
    // so the frame is cut with an abort pair instead
    if (tx_line_tick) begin
      if (!mode) begin  // see R3
        st_next.tx_state    = LAE_TX_IDLE;
        st_next.tx_esc_pend = 1'b0;
        tx_octet            = tx_in_valid ? tx_in_data : LAE_IDLE_CLEAR;
      end else if (st_reg.tx_esc_pend) begin
        tx_octet            = st_reg.tx_esc_oct;  // see R6
        st_next.tx_esc_pend = 1'b0;
      end else begin
        case (st_reg.tx_state)
          LAE_TX_IDLE: begin
            if (tx_in_valid) begin  // see R5
              st_next.tx_state = LAE_TX_HDR;
              st_next.tx_idx   = 2'h0;
              st_next.tx_crc   = LAE_CRC_INIT;
            end
          end
          LAE_TX_HDR: begin
            tx_use_raw     = 1'b1;
            tx_raw         = lae_octet_of(st_reg.hdr, LAE_LAST_IDX - st_reg.tx_idx);  // see R5
            st_next.tx_crc = lae_crc_byte(st_reg.tx_crc, tx_raw);
            st_next.tx_idx = st_reg.tx_idx + 2'h1;
            if (st_reg.tx_idx == LAE_LAST_IDX) begin
              st_next.tx_state = LAE_TX_DATA;
            end
          end
          LAE_TX_DATA: begin
            if (tx_in_valid) begin
              tx_use_raw     = 1'b1;
              tx_raw         = tx_in_data;
              st_next.tx_crc = lae_crc_byte(st_reg.tx_crc, tx_raw);
              if (tx_in_last) begin
                st_next.tx_state = LAE_TX_FCS;
                st_next.tx_idx   = 2'h0;
              end
            end else begin
              tx_octet         = LAE_ESC;
              st_next.tx_state = LAE_TX_CLOSE;
            end
          end
          LAE_TX_FCS: begin
            tx_use_raw     = 1'b1;
            tx_raw         = lae_octet_of(~st_reg.tx_crc, st_reg.tx_idx);  // see R5
            st_next.tx_idx = st_reg.tx_idx + 2'h1;
            if (st_reg.tx_idx == LAE_LAST_IDX) begin
              st_next.tx_state = LAE_TX_CLOSE;
            end
          end
          LAE_TX_CLOSE: begin
            st_next.tx_state = LAE_TX_IDLE;  // see R7
          end
          default: begin
            st_next.tx_state = LAE_TX_IDLE;
          end
        endcase
      end
      if (tx_use_raw) begin
        if (tx_raw == LAE_FLAG || tx_raw == LAE_ESC) begin  // see R6
          tx_octet            = LAE_ESC;
          st_next.tx_esc_pend = 1'b1;
          st_next.tx_esc_oct  = tx_raw ^ LAE_ESC_XOR;
        end else begin
          tx_octet = tx_raw;
        end
      end
      st_next.tx_data = tx_scr_out;  // see R7
    end
    st_next.tx_strobe = tx_line_tick;  // see R2

    // Receive octet per boundary strobe from the far end
    st_next.out_valid = 1'b0;
    st_next.out_start = 1'b0;
    st_next.out_end   = 1'b0;
    st_next.out_abort = 1'b0;
    if (rx_byte_boundary_strobe) begin  // see R1
      if (!mode) begin
        st_next.out_valid  = 1'b1;
        st_next.out_data   = rx_d;
        st_next.rx_state   = LAE_RX_HUNT;
        st_next.hold_valid = 1'b0;
      end else begin
        case (st_reg.rx_state)
          LAE_RX_HUNT: begin
            rx_restart = (rx_d == LAE_FLAG);  // see R9
          end
          LAE_RX_FRAME: begin
            if (st_reg.rx_esc) begin
              st_next.rx_esc = 1'b0;
              case (rx_d)
                LAE_ESC_FLAG: begin  // see R11
                  rx_accept = 1'b1;
                  rx_acc    = LAE_FLAG;
                end
                LAE_ESC_ESC: begin  // see R11
                  rx_accept = 1'b1;
                  rx_acc    = LAE_ESC;
                end
                LAE_RATE_ADAPT: ;  // see R10
                LAE_FLAG: begin  // see R14
                  rx_fin     = 1'b1;
                  rx_force   = 1'b1;
                  rx_restart = 1'b1;
                end
                default: begin  // see R18
                  rx_fin   = 1'b1;
                  rx_force = 1'b1;
                  rx_hunt  = 1'b1;
                end
              endcase
            end else if (rx_d == LAE_ESC) begin
              st_next.rx_esc = 1'b1;
            end else if (rx_d == LAE_FLAG) begin
              rx_fin     = (st_reg.rx_cnt != 4'h0);  // see R13
              rx_restart = 1'b1;
            end else begin
              rx_accept = 1'b1;
              rx_acc    = rx_d;
            end
          end
          default: begin
            rx_hunt = 1'b1;
          end
        endcase
      end
    end

    // Header octets are checked, payload is delayed one octet so the last
    // one can carry the end and abort marks
    if (rx_accept) begin
      st_next.rx_crc = lae_crc_byte(st_reg.rx_crc, rx_acc);
      if (st_reg.rx_cnt < LAE_HDR_OCTETS) begin
        if (rx_acc != lae_octet_of(st_reg.hdr, LAE_LAST_IDX - st_reg.rx_cnt[1:0])) begin  // see R12
          st_next.rx_hdr_bad = 1'b1;
        end
      end else begin
        st_next.out_valid  = st_reg.hold_valid;
        st_next.out_data   = st_reg.hold_data;
        st_next.out_start  = st_reg.hold_start;
        st_next.hold_data  = rx_acc;
        st_next.hold_start = (st_reg.rx_cnt == LAE_HDR_OCTETS);
        st_next.hold_valid = 1'b1;
      end
      if (st_reg.rx_cnt != LAE_CNT_MAX) begin
        st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
      end
    end
    if (rx_fin) begin
      rx_bad = rx_force || (st_reg.rx_cnt < LAE_MIN_OCTETS) ||  // see R16
               (st_reg.rx_crc != LAE_CRC_RESIDUE) ||              // see R15
               st_reg.rx_hdr_bad;                                 // see R17
      st_next.out_valid  = st_reg.hold_valid;
      st_next.out_data   = st_reg.hold_data;
      st_next.out_start  = st_reg.hold_start;
      st_next.out_end    = st_reg.hold_valid;
      st_next.out_abort  = st_reg.hold_valid && rx_bad;  // see R20
      st_next.hold_valid = 1'b0;
      if (rx_bad) begin
        st_next.abt_cnt = st_reg.abt_cnt + CNT_ONE;
      end else begin
        st_next.ok_cnt = st_reg.ok_cnt + CNT_ONE;
      end
    end
    if (rx_restart) begin
      st_next.rx_state   = LAE_RX_FRAME;
      st_next.rx_cnt     = 4'h0;
      st_next.rx_crc     = LAE_CRC_INIT;
      st_next.rx_hdr_bad = 1'b0;
      st_next.rx_esc     = 1'b0;
      st_next.hold_valid = 1'b0;
    end
    if (rx_hunt) begin
      st_next.rx_state   = LAE_RX_HUNT;
      st_next.hold_valid = 1'b0;
    end
  end

  // All state except the scrambler shift registers in one register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Checks on the framer and deframer
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_out_aborted;
    rx_out_valid && rx_out_end && rx_out_abort;
  endsequence

  sequence s_rx_in_frame;
    rx_byte_boundary_strobe && mode && st_reg.rx_state == LAE_RX_FRAME;
  endsequence

  property p_tx_strobe;
    tx_line_tick |=> tx_byte_boundary_strobe ##1 (tx_byte_boundary_strobe == $past(tx_line_tick));
  endproperty
  a_tx_strobe: assert property (p_tx_strobe) else $error("tx strobe missing");  // see R2

  property p_clear_path;
    (tx_line_tick && !mode && tx_in_valid && !st_reg.ctrl[LAE_CTRL_SCR]) |=> tx_line_data == $past(tx_in_data);
  endproperty
  a_clear_path: assert property (p_clear_path) else $error("clear path altered octet");  // see R3

  property p_tx_escape;
    (tx_line_tick && mode && !st_reg.tx_esc_pend && st_reg.tx_state == LAE_TX_DATA && tx_in_valid &&
     tx_in_data == LAE_FLAG && !st_reg.ctrl[LAE_CTRL_SCR])
      |=> tx_line_data == LAE_ESC && st_reg.tx_esc_pend && st_reg.tx_esc_oct == LAE_ESC_FLAG;
  endproperty
  a_tx_escape: assert property (p_tx_escape) else $error("flag not escaped");  // see R6

  property p_close_flag;
    (tx_line_tick && mode && !st_reg.tx_esc_pend && st_reg.tx_state == LAE_TX_CLOSE &&
     !st_reg.ctrl[LAE_CTRL_SCR]) |=> tx_line_data == LAE_FLAG && st_reg.tx_state == LAE_TX_IDLE;
  endproperty
  a_close_flag: assert property (p_close_flag) else $error("closing flag missing");  // see R7

  property p_rx_hunt;
    (rx_byte_boundary_strobe && mode && st_reg.rx_state == LAE_RX_HUNT && rx_d == LAE_FLAG)
      |=> st_reg.rx_state == LAE_RX_FRAME && st_reg.rx_cnt == 4'h0;
  endproperty
  a_rx_hunt: assert property (p_rx_hunt) else $error("flag not found");  // see R9

  property p_rate_adapt;
    (s_rx_in_frame and (st_reg.rx_esc && rx_d == LAE_RATE_ADAPT)) |=> !rx_out_valid && $stable(st_reg.rx_cnt);
  endproperty
  a_rate_adapt: assert property (p_rate_adapt) else $error("rate adaptation kept");  // see R10

  property p_abort_pair;
    (s_rx_in_frame and (st_reg.rx_esc && rx_d == LAE_FLAG && st_reg.hold_valid)) |=> s_out_aborted;
  endproperty
  a_abort_pair: assert property (p_abort_pair) else $error("abort pair ignored");  // see R14

  property p_fcs_bad;
    (rx_fin && st_reg.hold_valid && st_reg.rx_crc != LAE_CRC_RESIDUE) |=> s_out_aborted;
  endproperty
  a_fcs_bad: assert property (p_fcs_bad) else $error("bad fcs not aborted");  // see R15

  property p_short;
    (rx_fin && st_reg.hold_valid && st_reg.rx_cnt < LAE_MIN_OCTETS) |=> s_out_aborted;
  endproperty
  a_short: assert property (p_short) else $error("short frame not aborted");  // see R16

  property p_hdr_bad;
    (rx_fin && st_reg.hold_valid && st_reg.rx_hdr_bad) |=> s_out_aborted;
  endproperty
  a_hdr_bad: assert property (p_hdr_bad) else $error("header mismatch not aborted");  // see R17

  property p_good_end;
    (rx_fin && st_reg.hold_valid && !rx_force && st_reg.rx_cnt >= LAE_MIN_OCTETS && !st_reg.rx_hdr_bad &&
     st_reg.rx_crc == LAE_CRC_RESIDUE) |=> rx_out_valid && rx_out_end && !rx_out_abort;
  endproperty
  a_good_end: assert property (p_good_end) else $error("good frame aborted");  // see R13

endmodule : lae_top

// >>> design/lae_pkg.sv
// What this block does
// R1: Far end marks each receive octet with strobe
// R2: Transmit strobe marks each sent octet
// R3: Framing only when the mode bit is set
// R4: Programmable address, control, service-id octets
// R5: Send flag, header, payload, then 32-bit FCS
// R6: Escape 7E and 7D inside the frame
// R7: Append closing flag, then optional scrambling
// R8: Optional descrambling before any frame processing
// R9: Frame starts at a detected flag octet
// R10: Drop rate adaptation pairs 7D DD
// R11: Undo escape pairs back to original octets
// R12: Compare received header with programmed octets
// R13: Check FCS; closing flag ends the frame
// R14: Escape followed by flag aborts the frame
// R15: Bad FCS aborts the frame
// R16: Frames under six octets are aborted
// R17: Header mismatch aborts the frame
// R18: Escape before an illegal octet aborts
// R19: Descrambler free-runs self-synchronously, reset only at power-up
// R20: Aborted frames leave tagged with abort
package lae_pkg;

  // Octet codes of the framing layer
  localparam logic [7:0]  LAE_FLAG        = 8'h7E;
  localparam logic [7:0]  LAE_ESC         = 8'h7D;
  localparam logic [7:0]  LAE_ESC_FLAG    = 8'h5E;
  localparam logic [7:0]  LAE_ESC_ESC     = 8'h5D;
  localparam logic [7:0]  LAE_RATE_ADAPT  = 8'hDD;
  localparam logic [7:0]  LAE_ESC_XOR     = 8'h20;
  localparam logic [7:0]  LAE_IDLE_CLEAR  = 8'hFF;

  // Frame size figures, counted after unescaping
  localparam logic [3:0]  LAE_MIN_OCTETS  = 4'h6;
  localparam logic [3:0]  LAE_HDR_OCTETS  = 4'h4;
  localparam logic [3:0]  LAE_CNT_MAX     = 4'hF;
  localparam logic [1:0]  LAE_LAST_IDX    = 2'h3;

  // Scrambler polynomial x^43 + 1
  localparam int          LAE_SCR_LEN     = 43;

  // CRC-32, reflected, sent low octet first
  localparam logic [31:0] LAE_CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] LAE_CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] LAE_CRC_RESIDUE = 32'hDEBB20E3;

  // Register byte offsets and fields
  localparam logic [7:0]  LAE_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  LAE_OFF_HDR     = 8'h04;
  localparam logic [7:0]  LAE_OFF_RX_OK   = 8'h08;
  localparam logic [7:0]  LAE_OFF_RX_ABT  = 8'h0C;
  localparam int          LAE_CTRL_MODE   = 0;
  localparam int          LAE_CTRL_SCR    = 1;
  localparam int          LAE_CTRL_DSC    = 2;
  localparam logic [2:0]  LAE_CTRL_RST    = 3'h0;
  localparam logic [31:0] LAE_HDR_RST     = 32'h00000000;

  typedef enum logic [4:0] {
    LAE_TX_IDLE  = 5'b00001,
    LAE_TX_HDR   = 5'b00010,
    LAE_TX_DATA  = 5'b00100,
    LAE_TX_FCS   = 5'b01000,
    LAE_TX_CLOSE = 5'b10000
  } lae_tx_state_t;

  typedef enum logic [1:0] {
    LAE_RX_HUNT  = 2'b01,
    LAE_RX_FRAME = 2'b10
  } lae_rx_state_t;

  // One octet into the running CRC
  function automatic logic [31:0] lae_crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ LAE_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : lae_crc_byte

  // Octet idx of a word, idx 0 the lowest
  function automatic logic [7:0] lae_octet_of(input logic [31:0] w, input logic [1:0] idx);
    return w[{idx, 3'b000} +: 8];
  endfunction : lae_octet_of

endpackage : lae_pkg

// >>> design/lae_scrambler.sv
module lae_scrambler #(
  parameter bit DESCRAMBLE = 1'b0  // 1: feed back line bits
) (
  input  wire logic       hclk,      // Clock
  input  wire logic       hresetn,   // Power-up reset, active low
  input  wire logic       advance,   // Octet consumed this cycle
  input  wire logic       bypass,    // Pass octet unchanged
  input  wire logic [7:0] in_octet,  // Octet in, msb first on line
  output logic      [7:0] out_octet  // Octet out
);
  import lae_pkg::*;

  typedef struct packed {
    logic [LAE_SCR_LEN-1:0] sh;
  } lae_scr_st_t;

  lae_scr_st_t            st_reg;
  lae_scr_st_t            st_next;
  logic [LAE_SCR_LEN-1:0] work;
  logic [7:0]             mixed;

  // Eight bit steps per octet; the shift keeps running even when bypassed,
  // so turning the option on needs no resynchronisation
  always_comb begin
    st_next = st_reg;
    work    = st_reg.sh;
    mixed   = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      mixed[i] = in_octet[i] ^ work[LAE_SCR_LEN-1];
      work     = {work[LAE_SCR_LEN-2:0], DESCRAMBLE ? in_octet[i] : mixed[i]};
    end
    out_octet = bypass ? in_octet : mixed;
    if (advance) begin
      st_next.sh = work;
    end
  end

  // Only the power-up reset touches it; no frame event ever clears it
  always_ff @(posedge hclk or negedge hresetn) begin  // see R19
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : lae_scrambler

// >>> sim/lae_line.sv
module lae_line (
  input  wire logic       hclk,     // Clock
  input  wire logic       hresetn,  // Reset, active low
  input  wire logic       slow,     // Tick every other cycle
  input  wire logic       inj_en,   // Bench feeds receive side
  input  wire logic [7:0] inj_d,    // Injected octet
  input  wire logic       inj_s,    // Injected strobe
  input  wire logic [7:0] td,       // Sent octet
  input  wire logic       ts,       // Sent strobe
  output logic            tick,     // Line asks for an octet
  output logic      [7:0] rd,       // Received octet
  output logic            rs        // Received strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Loops sent octets back; between octets the data shows garbage so stale values never pass
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
      rs <= 1'b0;
      rd <= 8'h00;
    end else begin
      tick <= slow ? ~tick : 1'b1;
      rs <= inj_en ? inj_s : ts;
      rd <= (inj_en ? inj_s : ts) ? (inj_en ? inj_d : td) : ~rd;
    end
  end
endmodule : lae_line

// >>> sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lae_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_line_tick, tx_byte_boundary_strobe;
  logic        tx_in_valid, tx_in_last, tx_in_ready, rx_byte_boundary_strobe, rx_out_valid;
  logic        rx_out_start, rx_out_end, rx_out_abort, slow, inj_en, inj_s, loose;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  tx_line_data, tx_in_data, rx_line_data, rx_out_data, inj_d;
  logic [31:0] haddr, hwdata, hrdata, h, rv, ok0, ab0, x;
  logic [10:0] exq[$];
  logic [7:0]  pl[$], bd[$];
  int          miscompares, n_tests;

  lae_top lae_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .tx_line_tick, .tx_line_data, .tx_byte_boundary_strobe, .tx_in_valid,
    .tx_in_data, .tx_in_last, .tx_in_ready, .rx_line_data, .rx_byte_boundary_strobe, .rx_out_valid,
    .rx_out_data, .rx_out_start, .rx_out_end, .rx_out_abort);
  lae_line lae_line_i (.hclk, .hresetn, .slow, .inj_en, .inj_d, .inj_s, .td(tx_line_data),
    .ts(tx_byte_boundary_strobe), .tick(tx_line_tick), .rd(rx_line_data), .rs(rx_byte_boundary_strobe));

  // Random source and reference FCS, kept apart from the design's own function
  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h000000, d};
    repeat (8) c = c[0] ? ((c >> 1) ^ LAE_CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc
  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t word %h exp %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_oct(input logic [10:0] g, input logic [10:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t octet %h exp %h", $time, g, e);
    end
  endtask : chk_oct
  // Single AHB transfer; read data lands in rv
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus
  // Model: body is header, payload, FCS low octet first; header is not delivered
  task automatic mk(input int n, input logic [31:0] hd, input logic ab);
    logic [31:0] c;
    logic [31:0] v;
    pl = {};
    for (int k = 0; k < n; k++) begin
      v = xs();
      pl.push_back(v[1:0] == 2'h0 ? LAE_FLAG : v[1:0] == 2'h1 ? LAE_ESC : v[15:8]);
    end
    bd = {hd[31:24], hd[23:16], hd[15:8], hd[7:0], pl};
    c = 32'hFFFFFFFF;
    foreach (bd[k]) c = crc(c, bd[k]);
    c = ~c;
    bd = {bd, c[7:0], c[15:8], c[23:16], c[31:24]};
    for (int k = 4; k < bd.size(); k++) exq.push_back({k == bd.size() - 1 && ab, k == bd.size() - 1, k == 4, bd[k]});
  endtask : mk
  task automatic send();
    foreach (pl[k]) begin
      tx_in_valid <= 1'b1;
      tx_in_data <= pl[k];
      tx_in_last <= (k == pl.size() - 1);
      do @(posedge hclk); while (tx_in_ready !== 1'b1);
    end
    tx_in_valid <= 1'b0;
    tx_in_last <= 1'b0;
  endtask : send
  task automatic inj(input logic [7:0] b);
    inj_d <= b;
    inj_s <= 1'b1;
    @(posedge hclk);
    inj_s <= 1'b0;
    @(posedge hclk);
  endtask : inj
  task automatic inj_frame();
    inj(LAE_FLAG);
    foreach (bd[k]) begin
      if (bd[k] == LAE_FLAG || bd[k] == LAE_ESC) begin
        inj(LAE_ESC);
        inj(bd[k] ^ LAE_ESC_XOR);
      end else inj(bd[k]);
      if (k == 5) begin
        inj(LAE_ESC);
        inj(LAE_RATE_ADAPT);
      end
    end
    inj(LAE_FLAG);
  endtask : inj_frame
  task automatic drain();
    int k;
    k = 0;
    while (exq.size() > 0 && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    chk_reg(exq.size(), 0);
    repeat (4) @(posedge hclk);
  endtask : drain

  // Every delivered octet is checked against the model queue; in loose mode only end octets are checked, for the abort mark
  always @(posedge hclk) begin
    if (rx_out_valid === 1'b1) begin
      if (loose) begin
        if (rx_out_end === 1'b1) chk_oct({rx_out_abort, 10'h000}, 11'h400);
      end else if (exq.size() == 0) chk_oct(11'h000, 11'h7FF);
      else chk_oct({rx_out_abort, rx_out_end, rx_out_start, rx_out_data}, exq.pop_front());
    end
  end
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    end_sim();
  end
  initial begin
    {hsel, hwrite, tx_in_valid, tx_in_last, slow, inj_s, loose, htrans} = '0;
    {haddr, hwdata, tx_in_data, inj_d} = '0;
    hsize = 3'h2;
    inj_en = 1'b1;
    x = 32'h00000016;
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, 8'h10, xs());
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, k == 2 ? 8'h10 : {k[5:0], 2'h0}, 32'h0);
      chk_reg(rv, 32'h0);
    end
    h = xs();
    bus(1'b1, LAE_OFF_HDR, h);
    bus(1'b1, LAE_OFF_CTRL, 32'h7);
    bus(1'b0, LAE_OFF_HDR, 32'h0);
    chk_reg(rv, h);
    inj_en <= 1'b0;
    loose <= 1'b1;
    repeat (200) @(posedge hclk);
    loose <= 1'b0;
    bus(1'b0, LAE_OFF_RX_OK, 32'h0);
    ok0 = rv;
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      if (i == 4) bus(1'b1, LAE_OFF_CTRL, 32'h1);
      mk(i == 0 ? 1 : 2 + int'(xs() % 15), h, 1'b0);
      send();
      drain();
    end
    bus(1'b0, LAE_OFF_RX_OK, 32'h0);
    chk_reg(rv, ok0 + 6);
    bus(1'b0, LAE_OFF_RX_ABT, 32'h0);
    ab0 = rv;
    inj_en <= 1'b1;
    mk(5, h, 1'b0);
    inj_frame();
    drain();
    mk(3, h ^ 32'h00010000, 1'b1);
    inj_frame();
    drain();
    loose <= 1'b1;
    bd = {LAE_FLAG, h[31:24], h[23:16], h[15:8], h[7:0], 8'h55, LAE_ESC, LAE_FLAG, 8'h55, LAE_ESC, 8'h31,
          LAE_FLAG, LAE_FLAG, 8'h11, 8'h22, 8'h33, LAE_FLAG};
    foreach (bd[k]) inj(bd[k]);
    repeat (4) @(posedge hclk);
    loose <= 1'b0;
    bus(1'b0, LAE_OFF_RX_ABT, 32'h0);
    chk_reg(rv, ab0 + 4);
    bus(1'b1, LAE_OFF_CTRL, 32'h0);
    tx_in_valid <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      h = xs();
      exq.push_back({3'h0, h[7:0]});
      inj(h[7:0]);
    end
    drain();
    end_sim();
  end
endmodule : tb_top
